// ### hdl/ddr_pwr_ctrl.sv
// controller-side sequencer for power-down and self refresh
`timescale 1ns/1ps
`default_nettype none
module ddr_pwr_ctrl
	import cke_pwr_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire cke_pwr_pkg::cmd_t userCmd,
	input  wire logic [2:0] userBank,
	input  wire logic userAll,
	input  wire logic userOdt,
	input  wire logic userSlow,
	input  wire logic userValid,
	output logic      userReady,
	input  wire logic pdReq,
	input  wire logic srReq,
	input  wire logic wakeReq,
	output logic      lowPower,
	output logic      freqChangeOk,
	cke_link_if.ctrl  link
);
	import cke_pwr_pkg::*;

	logic       cke_ff;
	cmd_t       cmd_ff;
	logic [2:0] bank_ff;
	logic       all_ff;
	logic       odt_ff;
	logic       slow_ff;
	logic       inSr_ff;
	logic [7:0] hold_ff;
	logic       ckeLast_ff;
	logic [7:0] busy_ff;
	logic [7:0] newBusy;
	logic [7:0] exitWait_ff;
	logic       idleBanks_ff;
	logic [NUM_BANKS-1:0] open_ff;
	logic       holdOk;
	logic       canEnter;
	logic       issue;

	// RL12 three edges at a level
	assign holdOk   = hold_ff >= 8'(CKE_MIN_EDGES);
	// RL11 RL14 RL15 RL16 RL17 RL18 RL19 busy gate
	assign canEnter = holdOk && busy_ff == 8'h00 && exitWait_ff == 8'h00;
	// RL13 RL6 commands only when up and past exit wait
	assign userReady = cke_ff && holdOk && exitWait_ff == 8'h00 && !(pdReq || srReq);
	assign issue     = userValid && userReady;

	// link.cke is cke_ff itself, so the change is seen against a delayed copy
	always_ff @(posedge mclk) begin
		if (rst) begin
			hold_ff    <= 8'h00;
			ckeLast_ff <= 1'b1;
		end else begin
			ckeLast_ff <= cke_ff;
			if (cke_ff != ckeLast_ff)
				hold_ff <= 8'h01;
			else if (hold_ff != 8'hff)
				hold_ff <= hold_ff + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cke_ff  <= 1'b1;
			cmd_ff  <= CMD_NOP;
			inSr_ff <= 1'b0;
		end else begin
			cmd_ff <= CMD_NOP;
			if (cke_ff) begin
				if (issue)
					cmd_ff <= userCmd;
				// RL4 self refresh only with banks idle
				else if (srReq && canEnter && open_ff == '0) begin
					cke_ff  <= 1'b0;
					cmd_ff  <= CMD_REFRESH;
					inSr_ff <= 1'b1;
				// RL2 entry with nop
				end else if (pdReq && canEnter)
					cke_ff <= 1'b0;
			// RL5 RL21 RL8 exit with nop once held
			end else if (wakeReq && holdOk) begin
				cke_ff  <= 1'b1;
				inSr_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		case (userCmd)
			CMD_READ:      newBusy = 8'(READ_BURST + 1);
			CMD_WRITE:     newBusy = 8'(READ_BURST + WR_RECOVERY + 1);
			CMD_LOAD_MODE: newBusy = 8'(MRD_CLOCKS);
			default:       newBusy = 8'h01;
		endcase
	end

	// time until entry legal; a short command never cuts a longer wait short
	always_ff @(posedge mclk) begin
		if (rst)
			busy_ff <= 8'h00;
		else if (issue && newBusy > busy_ff)
			busy_ff <= newBusy;
		else if (busy_ff != 8'h00)
			busy_ff <= busy_ff - 8'h01;
	end

	// RL6 RL22 RL23 post-exit wait
	always_ff @(posedge mclk) begin
		if (rst)
			exitWait_ff <= 8'h00;
		else if (!cke_ff && wakeReq && holdOk)
			exitWait_ff <= inSr_ff ? 8'(XSRD_CLOCKS) :
				(slow_ff ? 8'(SLOW_EXIT_CLKS) : 8'(FAST_EXIT_CLKS));
		else if (exitWait_ff != 8'h00)
			exitWait_ff <= exitWait_ff - 8'h01;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			open_ff <= '0;
			slow_ff <= 1'b0;
		end else if (issue) begin
			if (userCmd == CMD_ACTIVATE)
				open_ff[userBank] <= 1'b1;
			else if (userCmd == CMD_PRECHARGE && userAll)
				open_ff <= '0;
			else if (userCmd == CMD_PRECHARGE)
				open_ff[userBank] <= 1'b0;
			if (userCmd == CMD_LOAD_MODE)
				slow_ff <= userSlow;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bank_ff <= 3'h0;
			all_ff  <= 1'b0;
		end else begin
			bank_ff <= userBank;
			all_ff  <= userAll;
		end
	end

	// RL10 RL9 RL22 odt driven low when down or relocking
	always_ff @(posedge mclk) begin
		if (rst)
			odt_ff <= 1'b0;
		else
			odt_ff <= userOdt && cke_ff && exitWait_ff == 8'h00;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			idleBanks_ff <= 1'b1;
		else
			idleBanks_ff <= (open_ff == '0);
	end

	assign lowPower = !cke_ff;
	// RL20 frequency change window
	assign freqChangeOk = !cke_ff && !inSr_ff && idleBanks_ff && hold_ff >= 8'(FREQ_WAIT) && !odt_ff;
	assign link.cke      = cke_ff;
	assign link.cmd      = cmd_ff;
	assign link.bank     = bank_ff;
	assign link.allBanks = all_ff;
	assign link.odt      = odt_ff;
	assign link.slowExit = slow_ff;
endmodule // ddr_pwr_ctrl
`default_nettype wire

// ### hdl/cke_pwr_pkg.sv
// constants and types for the clock-enable power-state logic
// How it works
// RL1 - device samples clock enable, uses previous/current pair
// RL2 - power-down entry/exit only with NOP/DESELECT
// RL3 - banks idle: precharge power-down, else active
// RL4 - CKE fall with REFRESH enters self refresh
// RL5 - self refresh exit only with NOP/DESELECT
// RL6 - exit-to-non-read NOPs; READ after 200 clocks
// RL7 - controller issues only permitted combinations
// RL8 - no refresh in power-down; exit in time
// RL9 - ODT ignored; termination off in self refresh
// RL10 - ODT driven valid during power-down
// RL11 - no entry while operations in progress
// RL12 - CKE held three edges after change
// RL13 - CKE steady high: only normal commands
// RL14 - after READ, entry after burst completes
// RL15 - write autoprecharge: entry one clock after precharge
// RL16 - precharge power-down one clock after REFRESH
// RL17 - active power-down one clock after ACTIVATE
// RL18 - precharge power-down one clock after PRECHARGE
// RL19 - mode load then power-down after delay
// RL20 - frequency change in precharge power-down, two clocks
// RL21 - stable clock before exit, then DLL reset
// RL22 - termination off during 200-cycle relock
// RL23 - mode bit 12 selects fast/slow exit
// RL24 - open rows kept through active power-down
package cke_pwr_pkg;
	localparam int NUM_BANKS      = 8;
	localparam int CKE_MIN_EDGES  = 3;
	localparam int XSRD_CLOCKS    = 200;
	localparam int XSNR_CLOCKS    = 200;
	localparam int RELOCK_CLOCKS  = 200;
	localparam int FREQ_WAIT      = 2;
	localparam int MRD_CLOCKS     = 2;
	localparam int READ_BURST     = 4;
	localparam int WR_RECOVERY    = 3;
	localparam int SLOW_EXIT_BIT  = 12;
	localparam int FAST_EXIT_CLKS = 2;
	localparam int SLOW_EXIT_CLKS = 6;

	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_DESELECT,
		CMD_ACTIVATE,
		CMD_READ,
		CMD_WRITE,
		CMD_PRECHARGE,
		CMD_REFRESH,
		CMD_LOAD_MODE
	} cmd_t;

	typedef enum logic [2:0] {
		PS_IDLE,
		PS_ACTIVE,
		PS_PRE_PD,
		PS_ACT_PD,
		PS_SELF_REF
	} pstate_t;
endpackage

// ### hdl/cke_link_if.sv
// link between controller and memory power-state logic
`timescale 1ns/1ps
`default_nettype none
interface cke_link_if;
	logic                     cke;
	cke_pwr_pkg::cmd_t        cmd;
	logic [2:0]               bank;
	logic                     allBanks;
	logic                     odt;
	logic                     slowExit;
	modport ctrl (output cke, output cmd, output bank, output allBanks, output odt, output slowExit);
	modport mem  (input cke, input cmd, input bank, input allBanks, input odt, input slowExit);
endinterface
`default_nettype wire

// ### hdl/dram_pwr_state.sv
// memory-side power-state tracker driven by clock enable
`timescale 1ns/1ps
`default_nettype none
module dram_pwr_state
	import cke_pwr_pkg::*;
(
	input  wire logic  mclk,
	input  wire logic  rst,
	cke_link_if.mem    link,
	output cke_pwr_pkg::pstate_t powerState,
	output logic [7:0] openRows,
	output logic       termActive,
	output logic       slowExitSel,
	output logic       illegalSeen
);
	import cke_pwr_pkg::*;

	logic    ckePrev_ff;
	pstate_t state_ff;
	logic [NUM_BANKS-1:0] open_ff;
	logic    slow_ff;
	logic    illegal_ff;
	logic    nopCmd;

	assign nopCmd = (link.cmd == CMD_NOP) || (link.cmd == CMD_DESELECT);

	// RL1 previous cke sample
	always_ff @(posedge mclk) begin
		if (rst)
			ckePrev_ff <= 1'b1;
		else
			ckePrev_ff <= link.cke;
	end

	// RL1 transition from cke pair
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_ff   <= PS_IDLE;
			illegal_ff <= 1'b0;
		end else begin
			case ({ckePrev_ff, link.cke})
				2'b11: state_ff <= (open_ff != '0) ? PS_ACTIVE : PS_IDLE;
				2'b10: begin
					// RL4 self refresh from idle only
					if (link.cmd == CMD_REFRESH && open_ff == '0)
						state_ff <= PS_SELF_REF;
					// RL2 RL3 entry kind from bank state
					else if (nopCmd)
						state_ff <= (open_ff != '0) ? PS_ACT_PD : PS_PRE_PD;
					else
						illegal_ff <= 1'b1;
				end
				2'b01: begin
					// RL2 exit only with nop
					if (!nopCmd)
						illegal_ff <= 1'b1;
					state_ff <= (open_ff != '0) ? PS_ACTIVE : PS_IDLE;
				end
				default: ;
			endcase
		end
	end

	// RL24 rows held while cke low
	always_ff @(posedge mclk) begin
		if (rst)
			open_ff <= '0;
		else if (ckePrev_ff && link.cke) begin
			case (link.cmd)
				CMD_ACTIVATE:  open_ff[link.bank] <= 1'b1;
				CMD_PRECHARGE: begin
					if (link.allBanks)
						open_ff <= '0;
					else
						open_ff[link.bank] <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	// RL23 exit speed from mode bit
	always_ff @(posedge mclk) begin
		if (rst)
			slow_ff <= 1'b0;
		else if (ckePrev_ff && link.cke && link.cmd == CMD_LOAD_MODE)
			slow_ff <= link.slowExit;
	end

	assign powerState  = state_ff;
	assign openRows    = open_ff;
	assign slowExitSel = slow_ff;
	assign illegalSeen = illegal_ff;
	// RL9 odt ignored; off in self refresh; RL8 no refresh while down
	assign termActive  = link.odt && (state_ff != PS_SELF_REF);
endmodule // dram_pwr_state
`default_nettype wire

// ### tb/dram_cke_power_state_control_assertions.sv
// link checks for the clock-enable power states
`timescale 1ns/1ps
`default_nettype none
module dram_cke_power_state_control_assertions
	import cke_pwr_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       cke,
	input wire cmd_t       cmd,
	input wire logic [2:0] bank,
	input wire logic       allBanks,
	input wire logic       odt,
	input wire logic       slowExit
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic       prevCke;
	logic       inSr;
	logic [7:0] srWait;
	logic       idleCmd;
	assign idleCmd = (cmd == CMD_NOP) || (cmd == CMD_DESELECT);
	// exit edge itself is checked apart, so 199 edges remain
	always_ff @(posedge mclk) begin
		if (rst) begin
			prevCke <= 1'b1;
			inSr    <= 1'b0;
			srWait  <= 8'h00;
		end else begin
			prevCke <= cke;
			if (prevCke && !cke && cmd == CMD_REFRESH)
				inSr <= 1'b1;
			if (!prevCke && cke && inSr) begin
				inSr   <= 1'b0;
				srWait <= 8'hc7;
			end else if (srWait != 8'h00)
				srWait <= srWait - 8'h01;
		end
	end
	a_cke_hold_three: assert property ($changed(cke) |=> $stable(cke) [*2])
		else $error("clock enable held under three edges");
	a_entry_cmd_ok: assert property ($fell(cke) |-> idleCmd || cmd == CMD_REFRESH)
		else $error("bad command at low-power entry");
	a_exit_cmd_nop: assert property ($rose(cke) |-> idleCmd)
		else $error("bad command at low-power exit");
	a_low_cmd_idle: assert property (!cke && !$fell(cke) |-> idleCmd)
		else $error("command issued while clock enable low");
	a_cmd_needs_cke: assert property (!idleCmd && cke |-> $past(cke))
		else $error("command without steady clock enable");
	a_sr_exit_wait: assert property (srWait != 8'h00 |-> idleCmd)
		else $error("command inside self refresh exit wait");
	a_read_keeps_cke: assert property (cmd == CMD_READ |-> cke [*4])
		else $error("clock enable dropped during read burst");
	a_write_keeps_cke: assert property (cmd == CMD_WRITE |-> cke [*4])
		else $error("clock enable dropped during write");
	a_load_keeps_cke: assert property (cmd == CMD_LOAD_MODE |-> cke [*2])
		else $error("clock enable dropped during mode load");
endmodule // dram_cke_power_state_control_assertions
`default_nettype wire

// ### tb/dram_cke_power_state_control_tb_top.sv
// self-checking bench for the controller and memory pair
`timescale 1ns/1ps
`default_nettype none
module dram_cke_power_state_control_tb_top;
	import cke_pwr_pkg::*;
	logic mclk, rst, userValid, userAll, userSlow, pdReq, srReq, wakeReq;
	logic userReady, lowPower, termActive, slowExitSel, illegalSeen;
	logic userOdt, freqChangeOk;
	cmd_t userCmd;
	logic [2:0] userBank;
	pstate_t powerState;
	logic [7:0] openRows;
	int nMismatch;
	int testsRun;
	cke_link_if link();
	ddr_pwr_ctrl i_ddr_pwr_ctrl(.mclk(mclk), .rst(rst), .userCmd(userCmd), .userBank(userBank),
		.userAll(userAll), .userOdt(userOdt), .userSlow(userSlow), .userValid(userValid),
		.userReady(userReady), .pdReq(pdReq), .srReq(srReq), .wakeReq(wakeReq),
		.lowPower(lowPower), .freqChangeOk(freqChangeOk), .link(link));
	dram_pwr_state i_dram_pwr_state(.mclk(mclk), .rst(rst), .link(link), .powerState(powerState),
		.openRows(openRows), .termActive(termActive), .slowExitSel(slowExitSel), .illegalSeen(illegalSeen));
	dram_cke_power_state_control_assertions chk(.mclk(mclk), .rst(rst), .cke(link.cke), .cmd(link.cmd),
		.bank(link.bank), .allBanks(link.allBanks), .odt(link.odt), .slowExit(link.slowExit));
	task automatic printVerdict();
		if (nMismatch == 0 && testsRun > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chkState(input string what, input pstate_t exp);
		testsRun++;
		if (powerState !== exp) begin
			nMismatch++;
			$display("Error %s expected %s seen %s", what, exp.name(), powerState.name());
		end
	endtask
	task automatic chkBits(input string what, input logic [7:0] exp, input logic [7:0] got);
		testsRun++;
		if (got !== exp) begin
			nMismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// gap cycle after each request keeps valid from toggling twice in one step
	task automatic issue(input cmd_t c, input logic [2:0] b, input logic a, input logic s);
		for (int i = 0; i < 300 && userReady !== 1'b1; i++) tick(1);
		userCmd = c;
		userBank = b;
		userAll = a;
		userSlow = s;
		userValid = 1'b1;
		tick(1);
		userValid = 1'b0;
		tick(1);
	endtask
	task automatic sleep(input logic self, input pstate_t exp);
		pdReq = !self;
		srReq = self;
		for (int i = 0; i < 50 && lowPower !== 1'b1; i++) tick(1);
		tick(2);
		pdReq = 1'b0;
		srReq = 1'b0;
		chkState("entry", exp);
	endtask
	task automatic wake(input pstate_t exp);
		tick(3);
		wakeReq = 1'b1;
		for (int i = 0; i < 50 && lowPower !== 1'b0; i++) tick(1);
		wakeReq = 1'b0;
		tick(2);
		chkState("exit", exp);
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		nMismatch++;
		printVerdict();
	end
	initial begin
		{rst, userValid, userAll, userSlow, pdReq, srReq, wakeReq} = 7'h40;
		userCmd = CMD_NOP;
		userBank = 3'h0;
		userOdt = 1'b1;
		nMismatch = 0;
		testsRun = 0;
		repeat (6) @(posedge mclk);
		#1 rst = 1'b0;
		tick(4);
		chkState("reset", PS_IDLE);
		chkBits("term", 8'h01, {7'h00, termActive});
		sleep(1'b0, PS_PRE_PD);
		chkBits("freq", 8'h01, {7'h00, freqChangeOk});
		chkBits("pdterm", 8'h00, {7'h00, termActive});
		wake(PS_IDLE);
		issue(CMD_ACTIVATE, 3'h5, 1'b0, 1'b0);
		sleep(1'b0, PS_ACT_PD);
		wake(PS_ACTIVE);
		chkBits("rows", 8'h20, openRows);
		issue(CMD_READ, 3'h5, 1'b0, 1'b0);
		issue(CMD_WRITE, 3'h5, 1'b0, 1'b0);
		issue(CMD_PRECHARGE, 3'h0, 1'b1, 1'b0);
		sleep(1'b0, PS_PRE_PD);
		wake(PS_IDLE);
		issue(CMD_LOAD_MODE, 3'h0, 1'b0, 1'b1);
		chkBits("slow", 8'h01, {7'h00, slowExitSel});
		issue(CMD_REFRESH, 3'h0, 1'b0, 1'b0);
		sleep(1'b1, PS_SELF_REF);
		chkBits("srterm", 8'h00, {7'h00, termActive});
		chkBits("srfreq", 8'h00, {7'h00, freqChangeOk});
		wake(PS_IDLE);
		chkBits("relock", 8'h00, {7'h00, termActive});
		issue(CMD_ACTIVATE, 3'h2, 1'b0, 1'b0);
		chkBits("rows", 8'h04, openRows);
		chkBits("illegal", 8'h00, {7'h00, illegalSeen});
		printVerdict();
	end
endmodule // dram_cke_power_state_control_tb_top
`default_nettype wire
